// ---- core/cpm_defs.svh ----
`ifndef CPM_DEFS_SVH
`define CPM_DEFS_SVH

// pll configuration word layout
`define CPM_CFG_W 20
`define CPM_M_HI 19
`define CPM_M_LO 12
`define CPM_P_HI 9
`define CPM_P_LO 4
`define CPM_S_HI 1
`define CPM_S_LO 0
`define CPM_M_W 9
`define CPM_P_W 7
`define CPM_S_W 2
`define CPM_M_OFS 8
`define CPM_P_OFS 2
`define CPM_CFG_RESET 20'h5C080

// boot strap decode
`define CPM_BOOT_MAIN_BIT 1
`define CPM_BOOT_USB_BIT 0
`define CPM_OP_TEST 2'h3

// timing
`define CPM_REF_PERIOD_NS 50
`define CPM_LOCK_MIN_NS 150000
`define CPM_LOCK_MIN_CYC ((`CPM_LOCK_MIN_NS + `CPM_REF_PERIOD_NS - 1) / `CPM_REF_PERIOD_NS)
`define CPM_SWITCH_GAP 2

`endif

// ---- core/cpm_pkg.sv ----
`default_nettype none
`include "cpm_defs.svh"

package cpm_pkg;

  typedef enum logic [2:0] {
    PM_NORMAL,
    PM_SLOW,
    PM_IDLE,
    PM_STOP,
    PM_LCD_IDLE
  } power_mode_t;

  typedef enum logic [1:0] {
    SW_DIRECT,
    SW_GAP_PLL,
    SW_PLL,
    SW_GAP_DIRECT
  } switch_state_t;

  typedef struct packed {
    logic [`CPM_M_W-1:0] m;
    logic [`CPM_P_W-1:0] p;
    logic [`CPM_S_W-1:0] s;
  } pll_div_t;

  typedef struct packed {
    logic cpu;
    logic ahb;
    logic apb;
    logic lcd;
    logic usb;
  } clk_gate_t;

endpackage

`default_nettype wire

// ---- core/pll_lock_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "cpm_defs.svh"

module pll_lock_ctrl #(
  parameter int LOCK_W = 16,
  parameter logic [`CPM_CFG_W-1:0] DEFAULT_CFG = `CPM_CFG_RESET
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic cfg_wr_i,
  input wire logic [`CPM_CFG_W-1:0] cfg_i,
  input wire logic relock_i,
  input wire logic [LOCK_W-1:0] lock_count_i,
  output cpm_pkg::pll_div_t div_o,
  output logic cfg_valid_o,
  output logic lock_busy_o,
  output logic use_pll_o
);

  if (LOCK_W < 1) begin : g_chk
    $error("pll_lock_ctrl: LOCK_W must be at least 1");
  end

  function automatic cpm_pkg::pll_div_t decode(input logic [`CPM_CFG_W-1:0] cfg);
    cpm_pkg::pll_div_t d;
    d.m = `CPM_M_W'(cfg[`CPM_M_HI:`CPM_M_LO]) + `CPM_M_W'(`CPM_M_OFS);
    d.p = `CPM_P_W'(cfg[`CPM_P_HI:`CPM_P_LO]) + `CPM_P_W'(`CPM_P_OFS);
    d.s = cfg[`CPM_S_HI:`CPM_S_LO];
    return d;
  endfunction

  localparam cpm_pkg::pll_div_t DIV_RESET = decode(DEFAULT_CFG);

  logic [LOCK_W-1:0] count_r;
  logic [LOCK_W-1:0] count_nxt;
  logic cfg_valid_r;
  cpm_pkg::pll_div_t div_r;

  wire start_w = cfg_wr_i | relock_i;
  wire busy_w = (count_r != '0);

  assign count_nxt = start_w ? lock_count_i : (busy_w ? count_r - LOCK_W'(1) : count_r);

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      count_r <= '0;
      cfg_valid_r <= 1'b0;
      div_r <= DIV_RESET;
    end else begin
      count_r <= count_nxt;
      if (cfg_wr_i) begin
        cfg_valid_r <= 1'b1;
        div_r <= decode(cfg_i);
      end
    end
  end

  assign div_o = div_r;
  assign cfg_valid_o = cfg_valid_r;
  assign lock_busy_o = busy_w;
  assign use_pll_o = cfg_valid_r & ~busy_w;

endmodule // pll_lock_ctrl

`default_nettype wire

// ---- core/clk_switch.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "cpm_defs.svh"

module clk_switch #(
  parameter int GAP = `CPM_SWITCH_GAP
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic want_pll_i,
  output logic sel_pll_o,
  output logic sel_direct_o,
  output logic switching_o
);

  if (GAP < 1) begin : g_chk
    $error("clk_switch: GAP must be at least 1");
  end

  localparam int GW = $clog2(GAP + 1);

  cpm_pkg::switch_state_t state_r;
  cpm_pkg::switch_state_t state_nxt;
  logic [GW-1:0] gap_r;
  logic [GW-1:0] gap_nxt;

  wire gap_done_w = (gap_r == '0);

  always_comb begin
    state_nxt = state_r;
    gap_nxt = (gap_r == '0) ? gap_r : gap_r - GW'(1);
    case (state_r)
      cpm_pkg::SW_DIRECT: begin
        if (want_pll_i) begin
          state_nxt = cpm_pkg::SW_GAP_PLL;
          gap_nxt = GW'(GAP);
        end
      end
      cpm_pkg::SW_GAP_PLL: begin
        if (gap_done_w) begin
          state_nxt = cpm_pkg::SW_PLL;
        end
      end
      cpm_pkg::SW_PLL: begin
        if (!want_pll_i) begin
          state_nxt = cpm_pkg::SW_GAP_DIRECT;
          gap_nxt = GW'(GAP);
        end
      end
      cpm_pkg::SW_GAP_DIRECT: begin
        if (gap_done_w) begin
          state_nxt = cpm_pkg::SW_DIRECT;
        end
      end
      default: begin
        state_nxt = cpm_pkg::SW_DIRECT;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      state_r <= cpm_pkg::SW_DIRECT;
      gap_r <= '0;
    end else begin
      state_r <= state_nxt;
      gap_r <= gap_nxt;
    end
  end

  // break before make: both selects low during the gap
  assign sel_pll_o = (state_r == cpm_pkg::SW_PLL);
  assign sel_direct_o = (state_r == cpm_pkg::SW_DIRECT);
  assign switching_o = ~sel_pll_o & ~sel_direct_o;

endmodule // clk_switch

`default_nettype wire

// ---- core/clock_power_manager.sv ----
// Behaviour
// - boot clock-select pins are caught at reset release and held afterwards.
// - boot code picks crystal or external source for main and usb.
// - operating-select 11 makes the boot code a test selection instead.
// - direct source drives clocks until a pll configuration is written.
// - pll divider values are m equals field plus 8, p equals field plus 2.
// - usb pll uses the same divider and configuration handling as main.
// - cpu clock held off while a new pll setting is locking.
// - lock interval of n reference periods after reset and after wake from stop or lcd-only idle.
// - relock on a config write, reset release or wake; switch to pll after the break-before-make gap that follows lock.
// - cpu, ahb and apb clocks produced; usb pll feeds the usb block.
// - per-peripheral enable bits gate each peripheral clock, except the lcd clock in lcd-only idle.
// - normal mode clocks cpu and every enabled peripheral.
// - slow mode drives cpu clock from the direct source, no pll.
// - idle gates only the cpu clock and wakes on any interrupt.
// - stop turns plls off, freezes all clocks, wakes on pin or alarm.
// - lcd-only idle keeps the lcd clock running and leaves the enabled usb clock gate open with the usb pll off; cpu, ahb and apb are gated.
`timescale 1ns/1ps
`default_nettype none
`include "cpm_defs.svh"

module clock_power_manager #(
  parameter int LOCK_W = 16,
  parameter int N_PERIPH = 16,
  parameter int LCD_IDX = 0,
  parameter logic [`CPM_CFG_W-1:0] MAIN_DEFAULT_CFG = `CPM_CFG_RESET,
  parameter logic [`CPM_CFG_W-1:0] USB_DEFAULT_CFG = `CPM_CFG_RESET
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [1:0] boot_clock_select_i,
  input wire logic [1:0] boot_operating_select_i,
  input wire logic main_pll_config_wr_i,
  input wire logic [`CPM_CFG_W-1:0] main_pll_config_i,
  input wire logic usb_pll_config_wr_i,
  input wire logic [`CPM_CFG_W-1:0] usb_pll_config_i,
  input wire logic [LOCK_W-1:0] main_lock_count_i,
  input wire logic [LOCK_W-1:0] usb_lock_count_i,
  input wire logic [N_PERIPH-1:0] periph_clk_enable_i,
  input wire logic usb_clk_enable_i,
  input wire logic mode_wr_i,
  input wire cpm_pkg::power_mode_t mode_i,
  input wire logic cpu_irq_i,
  input wire logic ext_irq_i,
  input wire logic rtc_alarm_i,
  output logic main_src_ext_o,
  output logic usb_src_ext_o,
  output logic test_mode_o,
  output logic [1:0] test_select_o,
  output cpm_pkg::pll_div_t main_pll_div_o,
  output cpm_pkg::pll_div_t usb_pll_div_o,
  output logic main_pll_on_o,
  output logic usb_pll_on_o,
  output logic cpu_clk_sel_pll_o,
  output logic cpu_clk_sel_direct_o,
  output logic usb_clk_sel_pll_o,
  output cpm_pkg::clk_gate_t clk_gate_o,
  output logic [N_PERIPH-1:0] periph_clk_en_o,
  output logic main_lock_busy_o,
  output logic usb_lock_busy_o,
  output logic lock_count_short_o,
  output cpm_pkg::power_mode_t power_mode_o
);

  if (N_PERIPH < 1 || LCD_IDX < 0 || LCD_IDX >= N_PERIPH) begin : g_chk_periph
    $error("clock_power_manager: LCD_IDX must index a peripheral");
  end
  if (LOCK_W < 1) begin : g_chk_lock
    $error("clock_power_manager: LOCK_W must be at least 1");
  end

  localparam int LOCK_MIN_CYC = `CPM_LOCK_MIN_CYC;

  // boot strap capture
  logic [1:0] boot_sel_r;
  logic [1:0] boot_op_r;
  logic rst_d_r;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      boot_sel_r <= boot_clock_select_i;
      boot_op_r <= boot_operating_select_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rst_d_r <= 1'b1;
    end else begin
      rst_d_r <= 1'b0;
    end
  end

  wire post_reset_w = rst_d_r & ~rst_i;
  wire test_w = (boot_op_r == `CPM_OP_TEST);
  wire main_ext_w = ~test_w & boot_sel_r[`CPM_BOOT_MAIN_BIT];
  wire usb_ext_w = ~test_w & boot_sel_r[`CPM_BOOT_USB_BIT];

  // power mode state
  cpm_pkg::power_mode_t mode_r;
  cpm_pkg::power_mode_t mode_nxt;
  logic wake_nxt;
  logic wake_r;

  wire wake_src_w = ext_irq_i | rtc_alarm_i;
  wire can_cmd_w = (mode_r == cpm_pkg::PM_NORMAL) || (mode_r == cpm_pkg::PM_SLOW);

  always_comb begin
    mode_nxt = mode_r;
    wake_nxt = 1'b0;
    case (mode_r)
      cpm_pkg::PM_NORMAL, cpm_pkg::PM_SLOW: begin
        if (mode_wr_i) begin
          mode_nxt = mode_i;
        end
      end
      cpm_pkg::PM_IDLE: begin
        if (cpu_irq_i || wake_src_w) begin
          mode_nxt = cpm_pkg::PM_NORMAL;
        end
      end
      cpm_pkg::PM_STOP: begin
        if (wake_src_w) begin
          mode_nxt = cpm_pkg::PM_NORMAL;
          wake_nxt = 1'b1;
        end
      end
      cpm_pkg::PM_LCD_IDLE: begin
        if (wake_src_w) begin
          mode_nxt = cpm_pkg::PM_NORMAL;
          wake_nxt = 1'b1;
        end
      end
      default: begin
        mode_nxt = cpm_pkg::PM_NORMAL;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      mode_r <= cpm_pkg::PM_NORMAL;
      wake_r <= 1'b0;
    end else begin
      mode_r <= mode_nxt;
      wake_r <= wake_nxt;
    end
  end

  // pll lock control
  logic main_busy;
  logic main_use_pll;
  logic usb_busy;
  logic usb_use_pll;

  wire relock_w = post_reset_w | wake_r;

  pll_lock_ctrl #(
    .LOCK_W(LOCK_W),
    .DEFAULT_CFG(MAIN_DEFAULT_CFG)
  ) u_main_lock (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .cfg_wr_i(main_pll_config_wr_i),
    .cfg_i(main_pll_config_i),
    .relock_i(relock_w),
    .lock_count_i(main_lock_count_i),
    .div_o(main_pll_div_o),
    .cfg_valid_o(),
    .lock_busy_o(main_busy),
    .use_pll_o(main_use_pll)
  );

  pll_lock_ctrl #(
    .LOCK_W(LOCK_W),
    .DEFAULT_CFG(USB_DEFAULT_CFG)
  ) u_usb_lock (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .cfg_wr_i(usb_pll_config_wr_i),
    .cfg_i(usb_pll_config_i),
    .relock_i(relock_w),
    .lock_count_i(usb_lock_count_i),
    .div_o(usb_pll_div_o),
    .cfg_valid_o(),
    .lock_busy_o(usb_busy),
    .use_pll_o(usb_use_pll)
  );

  // clock source switching
  logic cpu_sel_pll;
  logic cpu_sel_direct;
  logic cpu_switching;
  logic usb_sel_pll;
  logic usb_switching;

  wire slow_w = (mode_r == cpm_pkg::PM_SLOW);
  wire cpu_want_pll_w = main_use_pll & ~slow_w;

  clk_switch #(
    .GAP(`CPM_SWITCH_GAP)
  ) u_cpu_switch (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .want_pll_i(cpu_want_pll_w),
    .sel_pll_o(cpu_sel_pll),
    .sel_direct_o(cpu_sel_direct),
    .switching_o(cpu_switching)
  );

  clk_switch #(
    .GAP(`CPM_SWITCH_GAP)
  ) u_usb_switch (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .want_pll_i(usb_use_pll),
    .sel_pll_o(usb_sel_pll),
    .sel_direct_o(),
    .switching_o(usb_switching)
  );

  // clock gating decode
  wire run_w = (mode_r == cpm_pkg::PM_NORMAL) || slow_w;
  wire bus_mode_w = run_w || (mode_r == cpm_pkg::PM_IDLE);
  wire lcd_only_w = (mode_r == cpm_pkg::PM_LCD_IDLE);
  wire stop_w = (mode_r == cpm_pkg::PM_STOP);
  wire main_hold_w = main_busy | cpu_switching;

  wire cpu_en_w = run_w & ~main_hold_w;
  wire bus_en_w = bus_mode_w & ~main_hold_w;
  wire lcd_en_w = (bus_en_w & periph_clk_enable_i[LCD_IDX]) | lcd_only_w;
  wire usb_en_w = usb_clk_enable_i & ~stop_w & ~usb_busy & ~usb_switching;

  logic [N_PERIPH-1:0] periph_en_w;

  always_comb begin
    periph_en_w = periph_clk_enable_i & {N_PERIPH{bus_en_w}};
    periph_en_w[LCD_IDX] = lcd_en_w;
  end

  cpm_pkg::clk_gate_t gate_nxt;

  always_comb begin
    gate_nxt.cpu = cpu_en_w;
    gate_nxt.ahb = bus_en_w;
    gate_nxt.apb = bus_en_w;
    gate_nxt.lcd = lcd_en_w;
    gate_nxt.usb = usb_en_w;
  end

  cpm_pkg::clk_gate_t gate_r;
  logic [N_PERIPH-1:0] periph_en_r;
  logic main_pll_on_r;
  logic usb_pll_on_r;
  logic cpu_sel_pll_r;
  logic cpu_sel_direct_r;
  logic usb_sel_pll_r;
  logic short_r;

  wire main_short_w = (32'(main_lock_count_i) < 32'(LOCK_MIN_CYC));
  wire usb_short_w = (32'(usb_lock_count_i) < 32'(LOCK_MIN_CYC));

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      gate_r <= '0;
      periph_en_r <= '0;
      main_pll_on_r <= 1'b1;
      usb_pll_on_r <= 1'b1;
      cpu_sel_pll_r <= 1'b0;
      cpu_sel_direct_r <= 1'b1;
      usb_sel_pll_r <= 1'b0;
      short_r <= 1'b0;
    end else begin
      gate_r <= gate_nxt;
      periph_en_r <= periph_en_w;
      main_pll_on_r <= ~stop_w;
      usb_pll_on_r <= ~stop_w & ~lcd_only_w;
      cpu_sel_pll_r <= cpu_sel_pll;
      cpu_sel_direct_r <= cpu_sel_direct;
      usb_sel_pll_r <= usb_sel_pll;
      short_r <= main_short_w | usb_short_w;
    end
  end

  assign main_src_ext_o = main_ext_w;
  assign usb_src_ext_o = usb_ext_w;
  assign test_mode_o = test_w;
  assign test_select_o = test_w ? boot_sel_r : 2'h0;
  assign main_pll_on_o = main_pll_on_r;
  assign usb_pll_on_o = usb_pll_on_r;
  assign cpu_clk_sel_pll_o = cpu_sel_pll_r;
  assign cpu_clk_sel_direct_o = cpu_sel_direct_r;
  assign usb_clk_sel_pll_o = usb_sel_pll_r;
  assign clk_gate_o = gate_r;
  assign periph_clk_en_o = periph_en_r;
  assign main_lock_busy_o = main_busy;
  assign usb_lock_busy_o = usb_busy;
  assign lock_count_short_o = short_r;
  assign power_mode_o = mode_r;

endmodule // clock_power_manager

`default_nettype wire

// ---- verification/clock_power_manager_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "cpm_defs.svh"

module clock_power_manager_monitor #(
  parameter int LOCK_W = 16
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic main_pll_config_wr_i,
  input wire logic [`CPM_CFG_W-1:0] main_pll_config_i,
  input wire logic [LOCK_W-1:0] main_lock_count_i,
  input wire logic cpu_irq_i,
  input wire logic main_src_ext_o,
  input wire logic usb_src_ext_o,
  input wire cpm_pkg::pll_div_t main_pll_div_o,
  input wire logic main_pll_on_o,
  input wire logic cpu_clk_sel_pll_o,
  input wire logic cpu_clk_sel_direct_o,
  input wire cpm_pkg::clk_gate_t clk_gate_o,
  input wire logic main_lock_busy_o,
  input wire cpm_pkg::power_mode_t power_mode_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  property p_sel_excl;
    !(cpu_clk_sel_pll_o && cpu_clk_sel_direct_o);
  endproperty
  a_sel_excl: assert property (p_sel_excl) else $error("both cpu selects high");

  property p_main_div;
    main_pll_config_wr_i |=>
      main_pll_div_o.m == 9'($past(main_pll_config_i[`CPM_M_HI:`CPM_M_LO])) + 9'h008 &&
      main_pll_div_o.s == $past(main_pll_config_i[`CPM_S_HI:`CPM_S_LO]);
  endproperty
  a_main_div: assert property (p_main_div) else $error("main divider wrong");

  property p_lock_start;
    main_pll_config_wr_i && main_lock_count_i != '0 |=> main_lock_busy_o;
  endproperty
  a_lock_start: assert property (p_lock_start) else $error("lock did not start");

  property p_cpu_off;
    main_lock_busy_o |=> !clk_gate_o.cpu;
  endproperty
  a_cpu_off: assert property (p_cpu_off) else $error("cpu clocked during lock");

  property p_slow;
    (power_mode_o == cpm_pkg::PM_SLOW) [*8] |-> cpu_clk_sel_direct_o;
  endproperty
  a_slow: assert property (p_slow) else $error("slow mode not direct");

  property p_stop;
    power_mode_o == cpm_pkg::PM_STOP |=> clk_gate_o == '0 && !main_pll_on_o;
  endproperty
  a_stop: assert property (p_stop) else $error("clocks run in stop");

  property p_lcd;
    power_mode_o == cpm_pkg::PM_LCD_IDLE |=>
      clk_gate_o.lcd && !clk_gate_o.cpu && !clk_gate_o.ahb && !clk_gate_o.apb;
  endproperty
  a_lcd: assert property (p_lcd) else $error("lcd idle gates wrong");

  property p_idle_wake;
    power_mode_o == cpm_pkg::PM_IDLE && cpu_irq_i |=> power_mode_o == cpm_pkg::PM_NORMAL;
  endproperty
  a_idle_wake: assert property (p_idle_wake) else $error("idle did not wake");

  property p_strap;
    !$past(rst_i) |-> $stable(main_src_ext_o) && $stable(usb_src_ext_o);
  endproperty
  a_strap: assert property (p_strap) else $error("source changed after reset");
endmodule // clock_power_manager_monitor

bind clock_power_manager clock_power_manager_monitor #(.LOCK_W(LOCK_W)) monitor_inst (
  .ref_clk_i, .rst_i, .main_pll_config_wr_i, .main_pll_config_i, .main_lock_count_i,
  .cpu_irq_i, .main_src_ext_o, .usb_src_ext_o, .main_pll_div_o, .main_pll_on_o,
  .cpu_clk_sel_pll_o, .cpu_clk_sel_direct_o, .clk_gate_o, .main_lock_busy_o, .power_mode_o);
`default_nettype wire

// ---- verification/clk_consumer_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module clk_consumer_model (
  input wire logic ref_clk_i,
  input wire cpm_pkg::clk_gate_t gate_i,
  output logic [15:0] cpu_ticks_o
);
  // counts edges that reach the cpu through its gate
  initial cpu_ticks_o = 16'h0000;
  always @(posedge ref_clk_i) if (gate_i.cpu) cpu_ticks_o <= cpu_ticks_o + 16'h0001;
endmodule // clk_consumer_model
`default_nettype wire

// ---- verification/tb_clock_power_manager.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "cpm_defs.svh"

module tb_clock_power_manager;
  localparam int LC = 20;
  logic ref_clk_i, rst_i, main_pll_config_wr_i, usb_pll_config_wr_i, usb_clk_enable_i, mode_wr_i;
  logic [2:0] wk;
  logic [1:0] boot_clock_select_i, boot_operating_select_i, test_select_o;
  logic [`CPM_CFG_W-1:0] main_pll_config_i, usb_pll_config_i, c;
  logic [15:0] main_lock_count_i, usb_lock_count_i, periph_clk_enable_i, periph_clk_en_o;
  logic [15:0] cpu_ticks, t0;
  cpm_pkg::power_mode_t mode_i, power_mode_o;
  logic main_src_ext_o, usb_src_ext_o, test_mode_o, main_pll_on_o, usb_pll_on_o;
  logic cpu_clk_sel_pll_o, cpu_clk_sel_direct_o, usb_clk_sel_pll_o, lock_count_short_o;
  logic main_lock_busy_o, usb_lock_busy_o;
  cpm_pkg::pll_div_t main_pll_div_o, usb_pll_div_o;
  cpm_pkg::clk_gate_t clk_gate_o;
  int error_cnt = 0;
  int n_tests = 0;
  int seed = 17248;
  int cyc = 0;
  int k;

  clock_power_manager clock_power_manager_inst (.ref_clk_i, .rst_i, .boot_clock_select_i,
    .boot_operating_select_i, .main_pll_config_wr_i, .main_pll_config_i, .usb_pll_config_wr_i,
    .usb_pll_config_i, .main_lock_count_i, .usb_lock_count_i, .periph_clk_enable_i,
    .usb_clk_enable_i, .mode_wr_i, .mode_i, .cpu_irq_i(wk[2]), .ext_irq_i(wk[1]),
    .rtc_alarm_i(wk[0]), .main_src_ext_o, .usb_src_ext_o, .test_mode_o, .test_select_o,
    .main_pll_div_o, .usb_pll_div_o, .main_pll_on_o, .usb_pll_on_o, .cpu_clk_sel_pll_o,
    .cpu_clk_sel_direct_o, .usb_clk_sel_pll_o, .clk_gate_o, .periph_clk_en_o,
    .main_lock_busy_o, .usb_lock_busy_o, .lock_count_short_o, .power_mode_o);
  clk_consumer_model clk_consumer_model_inst (.ref_clk_i, .gate_i(clk_gate_o),
    .cpu_ticks_o(cpu_ticks));

  always #25 ref_clk_i = ~ref_clk_i;

  task automatic close_out();
    $display("errors %0d checks %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      close_out();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t got %0h exp %0h", $time, got, exp);
    end
  endtask

  function automatic cpm_pkg::pll_div_t exp_div(input logic [`CPM_CFG_W-1:0] v);
    exp_div.m = 9'(v[`CPM_M_HI:`CPM_M_LO]) + 9'h008;
    exp_div.p = 7'(v[`CPM_P_HI:`CPM_P_LO]) + 7'h02;
    exp_div.s = v[`CPM_S_HI:`CPM_S_LO];
  endfunction

  task automatic do_reset(input logic [1:0] bc, input logic [1:0] bo);
    @(posedge ref_clk_i);
    rst_i <= 1'b1;
    boot_clock_select_i <= bc;
    boot_operating_select_i <= bo;
    repeat (8) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    @(posedge ref_clk_i);
    boot_clock_select_i <= ~bc;
    boot_operating_select_i <= ~bo;
    repeat (2) @(posedge ref_clk_i);
    #1;
  endtask

  task automatic wr_cfg(input logic usb, input logic [`CPM_CFG_W-1:0] v);
    @(posedge ref_clk_i);
    main_pll_config_wr_i <= !usb;
    usb_pll_config_wr_i <= usb;
    main_pll_config_i <= v;
    usb_pll_config_i <= v;
    @(posedge ref_clk_i);
    main_pll_config_wr_i <= 1'b0;
    usb_pll_config_wr_i <= 1'b0;
    #1;
  endtask

  task automatic lock_len(input logic usb, output int n);
    n = 0;
    while ((usb ? usb_lock_busy_o : main_lock_busy_o) === 1'b1 && n < 1000) begin
      @(posedge ref_clk_i);
      #1;
      n++;
    end
  endtask

  task automatic set_mode(input cpm_pkg::power_mode_t m);
    @(posedge ref_clk_i);
    mode_wr_i <= 1'b1;
    mode_i <= m;
    @(posedge ref_clk_i);
    mode_wr_i <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    #1;
  endtask

  task automatic wake(input logic [2:0] w);
    @(posedge ref_clk_i);
    wk <= w;
    @(posedge ref_clk_i);
    wk <= 3'h0;
    repeat (3) @(posedge ref_clk_i);
    #1;
  endtask

  initial begin
    {ref_clk_i, rst_i, main_pll_config_wr_i, usb_pll_config_wr_i, mode_wr_i, wk} = 8'h40;
    {boot_clock_select_i, boot_operating_select_i, main_pll_config_i, usb_pll_config_i} = '0;
    {main_lock_count_i, usb_lock_count_i, periph_clk_enable_i} = {16'(LC), 16'(LC), 16'h0000};
    usb_clk_enable_i = 1'b1;
    mode_i = cpm_pkg::PM_NORMAL;
    for (int i = 0; i < 5; i++) begin
      do_reset(i == 0 ? 2'h2 : i[1:0], i == 0 ? 2'h3 : 2'h0);
      chk({test_mode_o, main_src_ext_o, usb_src_ext_o}, i == 0 ? 3'h4 : {1'b0, i[1:0]});
      chk(test_select_o, i == 0 ? 2'h2 : 2'h0);
    end
    lock_len(1'b0, k);
    chk({cpu_clk_sel_direct_o, cpu_clk_sel_pll_o, lock_count_short_o}, 3'h5);
    for (int i = 0; i < 6; i++) begin
      c = i == 0 ? 20'hFF3F3 : `CPM_CFG_W'($random(seed));
      wr_cfg(i[0], c);
      chk(i[0] ? usb_pll_div_o : main_pll_div_o, exp_div(c));
      lock_len(i[0], k);
      chk(k, LC);
      repeat (6) @(posedge ref_clk_i);
      #1;
      chk(i[0] ? {usb_clk_sel_pll_o, clk_gate_o.usb} : {cpu_clk_sel_pll_o, clk_gate_o.cpu}, 2'h3);
    end
    wr_cfg(1'b0, c);
    repeat (5) @(posedge ref_clk_i);
    wr_cfg(1'b0, c);
    chk(clk_gate_o.cpu, 1'b0);
    lock_len(1'b0, k);
    chk(k, LC);
    repeat (6) @(posedge ref_clk_i);
    for (int i = 0; i < 4; i++) begin
      @(posedge ref_clk_i);
      periph_clk_enable_i <= i == 0 ? 16'hFFFF : 16'($random(seed));
      repeat (3) @(posedge ref_clk_i);
      #1;
      chk(periph_clk_en_o, periph_clk_enable_i);
    end
    set_mode(cpm_pkg::PM_SLOW);
    repeat (6) @(posedge ref_clk_i);
    #1;
    chk({power_mode_o, cpu_clk_sel_direct_o, clk_gate_o.cpu}, {cpm_pkg::PM_SLOW, 2'h3});
    set_mode(cpm_pkg::PM_NORMAL);
    set_mode(cpm_pkg::PM_IDLE);
    chk({clk_gate_o.cpu, clk_gate_o.ahb, clk_gate_o.apb}, 3'h3);
    set_mode(cpm_pkg::PM_STOP);
    chk(power_mode_o, cpm_pkg::PM_IDLE);
    wake(3'h4);
    chk(power_mode_o, cpm_pkg::PM_NORMAL);
    set_mode(cpm_pkg::PM_STOP);
    t0 = cpu_ticks;
    wake(3'h4);
    chk({power_mode_o, clk_gate_o, main_pll_on_o, usb_pll_on_o, cpu_ticks}, {cpm_pkg::PM_STOP, 7'h00, t0});
    wake(3'h2);
    chk({power_mode_o, main_lock_busy_o}, {cpm_pkg::PM_NORMAL, 1'b1});
    lock_len(1'b0, k);
    set_mode(cpm_pkg::PM_LCD_IDLE);
    chk({clk_gate_o.cpu, clk_gate_o.ahb, clk_gate_o.apb, clk_gate_o.lcd, usb_pll_on_o}, 5'h02);
    wake(3'h1);
    chk({power_mode_o, main_lock_busy_o}, {cpm_pkg::PM_NORMAL, 1'b1});
    lock_len(1'b0, k);
    @(posedge ref_clk_i);
    {main_lock_count_i, usb_lock_count_i} <= {2{16'(`CPM_LOCK_MIN_CYC)}};
    repeat (2) @(posedge ref_clk_i);
    #1;
    chk(lock_count_short_o, 1'b0);
    @(posedge ref_clk_i);
    usb_lock_count_i <= 16'(`CPM_LOCK_MIN_CYC - 1);
    repeat (2) @(posedge ref_clk_i);
    #1;
    chk(lock_count_short_o, 1'b1);
    close_out();
  end
endmodule // tb_clock_power_manager
`default_nettype wire
